// ==== pkg/ccic_pkg.sv ====
/*
 Shared constants and enumerations for the control-channel I2C configuration block.
 Assumes a 200 MHz core clock; the wide watchdog counts are overridden by top parameters.
*/
package ccic_pkg;

   localparam int CLK_PERIOD_NS = 5;

   // Register offsets and reset values
   localparam logic [7:0] REG_CTRL2_OFS = 8'h06;
   localparam logic [7:0] REG_SER_ADDR_OFS = 8'h07;
   localparam logic [7:0] REG_TGT0_OFS = 8'h08;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] SER_ADDR_RST = 8'h18;
   localparam logic [7:0] TGT0_RST = 8'h00;

   // Field positions
   localparam int CTRL2_SEQ_ERR_BIT = 7;
   localparam int CTRL2_SEQ_CLR_BIT = 6;
   localparam int CTRL2_DLY_LSB = 3;
   localparam int CTRL2_RMT_LOCK_BIT = 2;
   localparam int CTRL2_WDT_FAST_BIT = 1;
   localparam int CTRL2_WDT_DIS_BIT = 0;
   localparam int ADDR_FIELD_LSB = 1;
   localparam int SER_LOCK_BIT = 0;

   // SDA output delay
   localparam int SDA_DLY_W = 7;
   localparam int SDA_BASE_NS = 250;
   localparam int SDA_STEP_NS = 50;
   localparam logic [6:0] SDA_BASE_CYC = 7'(SDA_BASE_NS / CLK_PERIOD_NS);
   localparam logic [6:0] SDA_STEP_CYC = 7'(SDA_STEP_NS / CLK_PERIOD_NS);

   // Bus watchdog and recovery
   localparam int IDLE_W = 28;
   localparam int WDT_FAST_MS = 50;
   localparam int WDT_SLOW_S = 1;
   localparam int BUS_FREE_S = 1;
   localparam logic [27:0] WDT_FAST_CYC = 28'(WDT_FAST_MS * 1000000 / CLK_PERIOD_NS);
   localparam logic [27:0] WDT_SLOW_CYC = 28'(WDT_SLOW_S * 1000000000 / CLK_PERIOD_NS);
   localparam logic [27:0] BUS_FREE_CYC = 28'(BUS_FREE_S * 1000000000 / CLK_PERIOD_NS);
   localparam int REC_HALF_NS = 5000;
   localparam logic [9:0] REC_HALF_CYC = 10'(REC_HALF_NS / CLK_PERIOD_NS);
   localparam logic [3:0] REC_PULSES = 4'h9;

   typedef enum logic [1:0] {
      REC_IDLE = 2'b00,
      REC_LOW = 2'b01,
      REC_HIGH = 2'b10
   } ccic_rec_e;

   typedef enum logic [2:0] {
      T_IDLE = 3'b000,
      T_ADDR = 3'b001,
      T_ACK = 3'b010,
      T_WR = 3'b011,
      T_RD = 3'b100,
      T_RACK = 3'b101,
      T_SKIP = 3'b110
   } ccic_tgt_e;

endpackage : ccic_pkg

// ==== pkg/ccic_lcl_if.sv ====
/*
 Carrier between the local I2C target and the configuration core.
 Assumes both ends run on the same core clock.
*/
`timescale 1ns/1ps
interface ccic_lcl_if;
   logic wr_stb;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] ptr;
   logic [7:0] rdata;
   logic [1:0] sda_dly;
   logic scl_s;
   logic sda_s;
   logic bus_act;
   logic addr_stb;
   logic [7:0] addr_byte;
   modport tgt (output wr_stb, waddr, wdata, ptr, scl_s, sda_s, bus_act, addr_stb, addr_byte,
                input rdata, sda_dly);
   modport core (input wr_stb, waddr, wdata, ptr, scl_s, sda_s, bus_act, addr_stb, addr_byte,
                 output rdata, sda_dly);
endinterface : ccic_lcl_if

// ==== logic/ccic_i2c_tgt.sv ====
/*
 Local I2C target: synchronises SCL/SDA, serves register reads and writes at its own
 address and reports any other address byte to the core. Assumes an external pull-up.
*/
`timescale 1ns/1ps
module ccic_i2c_tgt #(
   parameter logic [6:0] DEV_ADDR = 7'h2C
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // I2C pins
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Core side
   ccic_lcl_if.tgt lcl
);
   import ccic_pkg::*;

   typedef struct packed {
      logic scl_m; logic scl_s; logic scl_p;
      logic sda_m; logic sda_s; logic sda_p;
      ccic_tgt_e st; logic go_rd; logic [3:0] bitc; logic [7:0] sh; logic [7:0] ptr;
      logic first; logic nack; logic [6:0] dly; logic pend; logic want; logic oe;
      logic wr_stb; logic [7:0] waddr; logic [7:0] wdata; logic addr_stb; logic [7:0] addr_byte;
   } ccic_tgt_s;

   ccic_tgt_s q;
   ccic_tgt_s n;
   logic rise, fall, start, stop, drv_en, drv_val, load_rd;

   assign rise = q.scl_s && !q.scl_p;
   assign fall = !q.scl_s && q.scl_p;
   assign start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
   assign stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

   always_comb
   begin
      n = q;
      drv_en = 1'b0;
      drv_val = 1'b0;
      load_rd = 1'b0;
      n.wr_stb = 1'b0;
      n.addr_stb = 1'b0;
      {n.scl_m, n.scl_s, n.scl_p} = {scl_i, q.scl_m, q.scl_s};
      {n.sda_m, n.sda_s, n.sda_p} = {sda_i, q.sda_m, q.sda_s};
      if (q.pend)
      begin
         if (q.dly == 7'h00)
         begin
            n.oe = q.want;
            n.pend = 1'b0;
         end
         else
            n.dly = q.dly - 7'h01;
      end
      if (start || stop)
      begin
         n.st = start ? T_ADDR : T_IDLE;
         n.bitc = 4'h0;
         n.oe = 1'b0;
         n.pend = 1'b0;
      end
      else if (rise)
      begin
         if (q.st == T_ADDR || q.st == T_WR)
         begin
            n.sh = {q.sh[6:0], q.sda_s};
            n.bitc = q.bitc + 4'h1;
         end
         else if (q.st == T_RD)
            n.bitc = q.bitc + 4'h1;
         else if (q.st == T_RACK)
            n.nack = q.sda_s;
      end
      else if (fall)
      begin
         unique case (q.st)
            T_ADDR:
               if (q.bitc == 4'h8)
               begin
                  if (q.sh[7:1] == DEV_ADDR)
                  begin
                     n.st = T_ACK;
                     n.go_rd = q.sh[0];
                     n.first = 1'b1;
                     {drv_en, drv_val} = 2'b11;
                  end
                  else
                  begin
                     n.st = T_SKIP;
                     n.addr_stb = 1'b1;
                     n.addr_byte = q.sh;
                  end
               end
            T_WR:
               if (q.bitc == 4'h8)
               begin
                  n.st = T_ACK;
                  n.go_rd = 1'b0;
                  {drv_en, drv_val} = 2'b11;
                  n.first = 1'b0;
                  if (q.first)
                     n.ptr = q.sh;
                  else
                  begin
                     {n.wr_stb, n.waddr, n.wdata} = {1'b1, q.ptr, q.sh};
                     n.ptr = q.ptr + 8'h01;
                  end
               end
            T_ACK:
               begin
                  n.bitc = 4'h0;
                  load_rd = q.go_rd;
                  n.st = T_WR;
                  {drv_en, drv_val} = 2'b10;
               end
            T_RD:
               begin
                  drv_en = 1'b1;
                  if (q.bitc == 4'h8)
                     n.st = T_RACK;
                  else
                  begin
                     n.sh = {q.sh[6:0], 1'b0};
                     drv_val = !q.sh[6];
                  end
               end
            T_RACK:
               begin
                  load_rd = !q.nack;
                  n.st = T_SKIP;
                  {drv_en, drv_val} = 2'b10;
               end
            T_IDLE, T_SKIP: ;
            default: n.st = T_IDLE;
         endcase
         if (load_rd)
         begin
            n.st = T_RD;
            n.bitc = 4'h0;
            n.sh = lcl.rdata;
            n.ptr = q.ptr + 8'h01;
            drv_val = !lcl.rdata[7];
         end
      end
      if (drv_en)
      begin
         n.pend = 1'b1;
         n.want = drv_val;
         n.dly = SDA_BASE_CYC + 7'(lcl.sda_dly) * SDA_STEP_CYC;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         q <= '{scl_m: 1'b1, scl_s: 1'b1, scl_p: 1'b1, sda_m: 1'b1, sda_s: 1'b1, sda_p: 1'b1,
                st: T_IDLE, default: '0};
      else
         q <= n;
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = q.oe;
   assign lcl.wr_stb = q.wr_stb;
   assign lcl.waddr = q.waddr;
   assign lcl.wdata = q.wdata;
   assign lcl.ptr = q.ptr;
   assign lcl.scl_s = q.scl_s;
   assign lcl.sda_s = q.sda_s;
   assign lcl.bus_act = (q.scl_s ^ q.scl_p) | (q.sda_s ^ q.sda_p);
   assign lcl.addr_stb = q.addr_stb;
   assign lcl.addr_byte = q.addr_byte;

endmodule : ccic_i2c_tgt

// ==== logic/ccic_core.sv ====
/*
 Control-channel I2C configuration core: control/status, serializer address, first
 remote target, alias remap, bus watchdog with nine-pulse recovery. Assumes forward
 channel, back channel and remote-write inputs are on the core clock; SCL/SDA are pins.
*/
`timescale 1ns/1ps
module ccic_core #(
   parameter logic [6:0] DEV_ADDR = 7'h2C, // Arbitrary local address
   parameter logic [27:0] WDT_FAST_CYC = ccic_pkg::WDT_FAST_CYC,
   parameter logic [27:0] WDT_SLOW_CYC = ccic_pkg::WDT_SLOW_CYC,
   parameter logic [27:0] BUS_FREE_CYC = ccic_pkg::BUS_FREE_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   // Local I2C pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Forward channel
   input wire logic seq_err_i,
   input wire logic fwd_id_vld_i,
   input wire logic [6:0] fwd_id_i,
   // Remote register writes
   input wire logic rmt_wr_i,
   input wire logic [7:0] rmt_addr_i,
   input wire logic [7:0] rmt_data_i,
   output logic rmt_ack_o,
   output logic rmt_nak_o,
   // Forwarding configuration and request
   input wire logic [6:0] local_alias_addr0_i,
   input wire logic pass_all_i,
   output logic fwd_vld_o,
   output logic [6:0] fwd_addr_o,
   output logic fwd_rnw_o,
   // Bus status
   output logic bus_free_o
);
   import ccic_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic seq_err;
      logic seq_clr;
      logic [1:0] sda_dly;
      logic rmt_lock;
      logic wdt_fast;
      logic wdt_dis;
      logic [6:0] ser_addr;
      logic ser_lock;
      logic [6:0] tgt0;
      logic [27:0] idle;
      logic bus_free;
      ccic_rec_e rec;
      logic [9:0] half;
      logic [3:0] pulses;
      logic scl_oe;
      logic rmt_ack;
      logic rmt_nak;
      logic fwd_vld;
      logic [6:0] fwd_addr;
      logic fwd_rnw;
   } ccic_core_s;

   localparam ccic_core_s CORE_RST = '{
      seq_err: CTRL2_RST[CTRL2_SEQ_ERR_BIT],
      seq_clr: CTRL2_RST[CTRL2_SEQ_CLR_BIT],
      sda_dly: CTRL2_RST[CTRL2_DLY_LSB +: 2],
      rmt_lock: CTRL2_RST[CTRL2_RMT_LOCK_BIT],
      wdt_fast: CTRL2_RST[CTRL2_WDT_FAST_BIT],
      wdt_dis: CTRL2_RST[CTRL2_WDT_DIS_BIT],
      ser_addr: SER_ADDR_RST[ADDR_FIELD_LSB +: 7],
      ser_lock: SER_ADDR_RST[SER_LOCK_BIT],
      tgt0: TGT0_RST[ADDR_FIELD_LSB +: 7],
      rec: REC_IDLE,
      default: '0
   };

   ccic_core_s q;
   ccic_core_s n;
   ccic_lcl_if lcl ();
   logic [6:0] addr7;
   logic [27:0] lim;
   logic ser_hit;
   logic alias_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // Register access

   function automatic ccic_core_s reg_wr(input ccic_core_s s, input logic [7:0] a,
                                         input logic [7:0] d);
      ccic_core_s r;
      r = s;
      if (a == REG_CTRL2_OFS)
      begin
         r.seq_clr = d[CTRL2_SEQ_CLR_BIT];
         r.sda_dly = d[CTRL2_DLY_LSB +: 2];
         r.rmt_lock = d[CTRL2_RMT_LOCK_BIT];
         r.wdt_fast = d[CTRL2_WDT_FAST_BIT];
         r.wdt_dis = d[CTRL2_WDT_DIS_BIT];
      end
      else if (a == REG_SER_ADDR_OFS)
      begin
         r.ser_addr = d[ADDR_FIELD_LSB +: 7];
         r.ser_lock = d[SER_LOCK_BIT];
      end
      else if (a == REG_TGT0_OFS)
         r.tgt0 = d[ADDR_FIELD_LSB +: 7];
      return r;
   endfunction : reg_wr

   function automatic logic [7:0] reg_rd(input ccic_core_s s, input logic [7:0] a);
      logic [7:0] v;
      v = 8'h00;
      if (a == REG_CTRL2_OFS)
      begin
         v[CTRL2_SEQ_ERR_BIT] = s.seq_err;
         v[CTRL2_SEQ_CLR_BIT] = s.seq_clr;
         v[CTRL2_DLY_LSB +: 2] = s.sda_dly;
         v[CTRL2_RMT_LOCK_BIT] = s.rmt_lock;
         v[CTRL2_WDT_FAST_BIT] = s.wdt_fast;
         v[CTRL2_WDT_DIS_BIT] = s.wdt_dis;
      end
      else if (a == REG_SER_ADDR_OFS)
         v = {s.ser_addr, s.ser_lock};
      else if (a == REG_TGT0_OFS)
         v = {s.tgt0, 1'b0};
      return v;
   endfunction : reg_rd

   ccic_i2c_tgt #(
      .DEV_ADDR(DEV_ADDR)
   ) u_tgt (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .scl_i(scl_i),
      .sda_i(sda_i),
      .sda_o(sda_o),
      .sda_oe_o(sda_oe_o),
      .lcl(lcl.tgt)
   );

   assign lcl.rdata = reg_rd(q, lcl.ptr);
   assign lcl.sda_dly = q.sda_dly;
   assign addr7 = lcl.addr_byte[7:1];
   assign lim = q.wdt_fast ? WDT_FAST_CYC : WDT_SLOW_CYC;
   assign ser_hit = (q.ser_addr != 7'h00) && (addr7 == q.ser_addr);
   assign alias_hit = (local_alias_addr0_i != 7'h00) && (addr7 == local_alias_addr0_i);

   ////////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      n = q;
      n.rmt_ack = 1'b0;
      n.rmt_nak = 1'b0;
      n.fwd_vld = 1'b0;
      if (fwd_id_vld_i && !q.ser_lock)
         n.ser_addr = fwd_id_i;
      if (rmt_wr_i)
      begin
         if (q.rmt_lock)
            n.rmt_nak = 1'b1;
         else
         begin
            n = reg_wr(n, rmt_addr_i, rmt_data_i);
            n.rmt_ack = 1'b1;
         end
      end
      if (lcl.wr_stb)
         n = reg_wr(n, lcl.waddr, lcl.wdata);
      if (n.seq_clr)
         n.seq_err = 1'b0;
      else if (seq_err_i)
         n.seq_err = 1'b1;
      // Forwarding decision for non-local addresses
      if (lcl.addr_stb)
      begin
         n.fwd_rnw = lcl.addr_byte[0];
         if (ser_hit)
            {n.fwd_vld, n.fwd_addr} = {1'b1, addr7};
         else if (alias_hit)
            {n.fwd_vld, n.fwd_addr} = {1'b1, q.tgt0};
         else if (pass_all_i)
            {n.fwd_vld, n.fwd_addr} = {1'b1, addr7};
      end
      // Bus watchdog and recovery
      unique case (q.rec)
         REC_IDLE:
            begin
               if (lcl.bus_act || q.wdt_dis)
               begin
                  n.idle = '0;
                  n.bus_free = 1'b0;
               end
               else
               begin
                  if (q.idle != '1)
                     n.idle = q.idle + 28'h0000001;
                  if (lcl.sda_s && q.idle >= BUS_FREE_CYC)
                     n.bus_free = 1'b1;
                  if (!lcl.sda_s && q.idle >= lim)
                  begin
                     n.rec = REC_LOW;
                     n.scl_oe = 1'b1;
                     n.half = '0;
                     n.pulses = '0;
                     n.idle = '0;
                     n.bus_free = 1'b0;
                  end
               end
            end
         REC_LOW:
            if (q.half == REC_HALF_CYC - 10'h001)
            begin
               n.rec = REC_HIGH;
               n.scl_oe = 1'b0;
               n.half = '0;
            end
            else
               n.half = q.half + 10'h001;
         REC_HIGH:
            if (q.half == REC_HALF_CYC - 10'h001)
            begin
               n.half = '0;
               n.pulses = q.pulses + 4'h1;
               if (q.pulses == REC_PULSES - 4'h1)
                  n.rec = REC_IDLE;
               else
               begin
                  n.rec = REC_LOW;
                  n.scl_oe = 1'b1;
               end
            end
            else
               n.half = q.half + 10'h001;
         default:
            begin
               n.rec = REC_IDLE;
               n.scl_oe = 1'b0;
            end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
         q <= CORE_RST;
      else
         q <= n;
   end

   assign scl_o = 1'b0;
   assign scl_oe_o = q.scl_oe;
   assign rmt_ack_o = q.rmt_ack;
   assign rmt_nak_o = q.rmt_nak;
   assign fwd_vld_o = q.fwd_vld;
   assign fwd_addr_o = q.fwd_addr;
   assign fwd_rnw_o = q.fwd_rnw;
   assign bus_free_o = q.bus_free;

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   sequence s_stuck;
      q.rec == REC_IDLE && !q.wdt_dis && !lcl.bus_act && !lcl.sda_s && q.idle >= lim;
   endsequence

   sequence s_rec_end;
      q.rec == REC_HIGH ##1 q.rec == REC_IDLE;
   endsequence

   a_seq_err_set: assert property (seq_err_i && !q.seq_clr && !lcl.wr_stb && !rmt_wr_i
      |=> q.seq_err) else $error("sequence error not flagged");
   a_seq_clr_keep: assert property (q.seq_clr && !lcl.wr_stb && !rmt_wr_i
      |=> q.seq_clr) else $error("clear bit changed by itself");
   a_seq_err_hold: assert property (q.seq_clr |-> !q.seq_err)
      else $error("error flag set while clear bit is one");
   a_rmt_wr_block: assert property (rmt_wr_i && q.rmt_lock && !lcl.wr_stb
      |=> rmt_nak_o && !rmt_ack_o && $stable(q.tgt0) && $stable(q.sda_dly))
      else $error("remote write not refused");
   a_addr_load: assert property (fwd_id_vld_i && !q.ser_lock && !lcl.wr_stb && !rmt_wr_i
      |=> q.ser_addr == $past(fwd_id_i)) else $error("serializer address not loaded");
   a_addr_lock: assert property (fwd_id_vld_i && q.ser_lock && !lcl.wr_stb && !rmt_wr_i
      |=> $stable(q.ser_addr)) else $error("locked address overwritten");
   a_alias_remap: assert property (lcl.addr_stb && alias_hit && !ser_hit
      |=> fwd_vld_o && fwd_addr_o == $past(q.tgt0)) else $error("alias not remapped");
   a_ser_zero: assert property (lcl.addr_stb && q.ser_addr == 7'h00 && !alias_hit && !pass_all_i
      |=> !fwd_vld_o) else $error("zero serializer address forwarded");
   a_pass_all: assert property (lcl.addr_stb && pass_all_i |=> fwd_vld_o)
      else $error("pass-through-all did not forward");
   a_wdt_limit: assert property ($rose(q.scl_oe) && $past(q.rec) == REC_IDLE
      |-> $past(q.idle) >= $past(lim)) else $error("recovery before watchdog expiry");
   a_wdt_off: assert property (q.wdt_dis && q.rec == REC_IDLE |=> q.rec == REC_IDLE)
      else $error("recovery with watchdog disabled");
   a_bus_free: assert property (q.rec == REC_IDLE && !q.wdt_dis && !lcl.bus_act && lcl.sda_s
      && q.idle >= BUS_FREE_CYC |=> bus_free_o) else $error("bus free not reported");
   a_rec_start: assert property (s_stuck |=> q.rec == REC_LOW && scl_oe_o)
      else $error("stuck bus not recovered");
   a_rec_nine: assert property (s_rec_end |-> q.pulses == REC_PULSES)
      else $error("recovery pulse count wrong");

endmodule : ccic_core

// ==== bench/ccic_host_model.sv ====
/*
 I2C host model: drives SCL and SDA open drain, MSB first, ninth bit acknowledge.
 Assumes the bench resolves both wires with pull-ups.
*/
`timescale 1ns/1ps
module ccic_host_model #(
   parameter int HALF = 80
) (
   // Clock and bus
   input wire logic ref_clk_i,
   input wire logic sda_i,
   output logic scl_oe_o,
   output logic sda_oe_o
);
   initial
   begin
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
   end

   task automatic hw(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : hw

   task automatic hold(input logic v);
      sda_oe_o = v;
   endtask : hold

   // Start or repeated start
   task automatic start();
      hw(20);
      sda_oe_o = 1'b0;
      hw(HALF);
      scl_oe_o = 1'b0;
      hw(HALF);
      sda_oe_o = 1'b1;
      hw(HALF);
      scl_oe_o = 1'b1;
   endtask : start

   task automatic stop();
      hw(20);
      sda_oe_o = 1'b1;
      hw(HALF);
      scl_oe_o = 1'b0;
      hw(HALF);
      sda_oe_o = 1'b0;
      hw(HALF);
   endtask : stop

   task automatic xfer(input logic [8:0] d, output logic [8:0] q);
      for (int i = 8; i >= 0; i--)
      begin
         hw(20);
         sda_oe_o = ~d[i];
         hw(HALF);
         scl_oe_o = 1'b0;
         hw(HALF);
         q[i] = sda_i;
         scl_oe_o = 1'b1;
      end
   endtask : xfer
endmodule : ccic_host_model

// ==== bench/ccic_core_test.sv ====
/*
 Bench for ccic_core: I2C host model, forward channel and remote writes, integer model.
 Assumes shortened watchdog counts and the default local address.
*/
`timescale 1ns/1ps
module ccic_core_test;
   import ccic_pkg::*;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic seq_err_i;
   logic fwd_id_vld_i;
   logic rmt_wr_i;
   logic pass_all_i;
   logic [6:0] fwd_id_i;
   logic [6:0] alias0;
   logic [7:0] rmt_addr_i;
   logic [7:0] rmt_data_i;
   logic scl_d = 1'b1;
   logic oe_d = 1'b0;
   logic scl_oe, sda_oe, h_scl, h_sda, ack, nak, fvld, frnw, bus_free;
   logic [6:0] faddr;
   logic [7:0] last_fwd;
   logic [8:0] q;
   wire scl = ~(scl_oe | h_scl);
   wire sda = ~(sda_oe | h_sda);
   int n_errors = 0, n_compared = 0, seed = 54, m6 = 0, m7 = 8'h18, m8 = 0, n_fwd = 0;
   int n_rec = 0, n_edge = 0, dly_seen = 0;

   always #2.5 ref_clk_i = ~ref_clk_i;

   ccic_core #(
      .WDT_FAST_CYC(28'h00000C8), .WDT_SLOW_CYC(28'h0000190), .BUS_FREE_CYC(28'h000012C)
   ) dut (
      .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe),
      .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .seq_err_i(seq_err_i),
      .fwd_id_vld_i(fwd_id_vld_i), .fwd_id_i(fwd_id_i), .rmt_wr_i(rmt_wr_i),
      .rmt_addr_i(rmt_addr_i), .rmt_data_i(rmt_data_i), .rmt_ack_o(ack), .rmt_nak_o(nak),
      .local_alias_addr0_i(alias0), .pass_all_i(pass_all_i), .fwd_vld_o(fvld),
      .fwd_addr_o(faddr), .fwd_rnw_o(frnw), .bus_free_o(bus_free)
   );

   ccic_host_model host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_oe_o(h_scl), .sda_oe_o(h_sda));

   always @(posedge ref_clk_i)
   begin
      if (fvld === 1'b1)
      begin
         n_fwd++;
         last_fwd = {faddr, frnw};
      end
      if ($rose(scl_oe))
         n_rec++;
      // Edges since the last SCL pin fall, latched at each SDA drive change
      n_edge = (scl_d === 1'b1 && scl === 1'b0) ? 1 : n_edge + 1;
      if (sda_oe !== oe_d)
         dly_seen = n_edge;
      scl_d = scl;
      oe_d = sda_oe;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask : cyc

   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", w, e, g);
         n_errors++;
      end
   endtask : chk

   // Model update for an accepted write
   task automatic mw(input logic [7:0] a, input logic [7:0] d);
      if (a == REG_CTRL2_OFS)
         m6 = (d[6] ? 8'h00 : m6 & 8'h80) | (d & 8'h5F);
      if (a == REG_SER_ADDR_OFS)
         m7 = d;
      if (a == REG_TGT0_OFS)
         m8 = d & 8'hFE;
   endtask : mw

   task automatic rmt(input logic [7:0] a, input logic [7:0] d, input logic n);
      int i;
      rmt_addr_i = a;
      rmt_data_i = d;
      rmt_wr_i = 1'b1;
      cyc(1);
      rmt_wr_i = 1'b0;
      for (i = 0; i < 3 && ack !== 1'b1 && nak !== 1'b1; i++)
         cyc(1);
      chk("remote nak", {7'h00, n}, {7'h00, nak});
      chk("remote ack", {7'h00, ~n}, {7'h00, ack});
      if (!n)
         mw(a, d);
      if (i == 3)
         give_verdict();
   endtask : rmt

   task automatic fside(input logic e, input logic [6:0] id);
      seq_err_i = e;
      fwd_id_vld_i = ~e;
      fwd_id_i = id;
      cyc(1);
      seq_err_i = 1'b0;
      fwd_id_vld_i = 1'b0;
      if (e && !m6[6])
         m6 = m6 | 8'h80;
      if (!e && !m7[0])
         m7 = {id, m7[0]};
      cyc(2);
   endtask : fside

   task automatic snd(input logic [7:0] d);
      host.xfer({d, 1'b1}, q);
      chk("target ack", 8'h00, {7'h00, q[0]});
   endtask : snd

   // Burst read 0x06 to 0x09; the last offset is unmapped
   task automatic rd4();
      int e;
      host.start();
      snd(8'h58);
      snd(REG_CTRL2_OFS);
      host.start();
      snd(8'h59);
      for (int i = 0; i < 4; i++)
      begin
         host.xfer({8'hFF, i == 3}, q);
         chk("register read", 8'(i == 0 ? m6 : i == 1 ? m7 : i == 2 ? m8 : 0), q[8:1]);
      end
      host.stop();
      // Sync, edge detect, update and bench sample add five edges
      e = (SDA_BASE_NS + SDA_STEP_NS * ((m6 >> 3) & 3)) / CLK_PERIOD_NS + 5;
      chk("sda delay", 8'(e), 8'(dly_seen));
   endtask : rd4

   task automatic wr(input logic [7:0] d6, input logic [7:0] d7, input logic [7:0] d8,
                     input int n);
      logic [7:0] b [3];
      b = '{d6, d7, d8};
      host.start();
      snd(8'h58);
      snd(REG_CTRL2_OFS);
      for (int i = 0; i < n; i++)
      begin
         snd(b[i]);
         mw(8'(REG_CTRL2_OFS + i), b[i]);
      end
      host.stop();
   endtask : wr

   task automatic ftry(input logic [7:0] ab, input int inc, input logic [7:0] e);
      int n0;
      n0 = n_fwd;
      host.start();
      host.xfer({ab, 1'b1}, q);
      host.stop();
      chk("forward count", 8'(inc), 8'(n_fwd - n0));
      if (inc != 0)
         chk("forward target", e, last_fwd);
   endtask : ftry

   initial
   begin
      int r0;
      int i;
      {seq_err_i, fwd_id_vld_i, rmt_wr_i, pass_all_i} = 4'h0;
      {fwd_id_i, rmt_addr_i, rmt_data_i} = 23'h000000;
      alias0 = {3'h5, 4'($random(seed))};
      cyc(4);
      arst_n_i = 1'b1;
      cyc(3);
      rd4();
      $display("reset values done");
      rmt(REG_TGT0_OFS, 8'($random(seed)), 1'b0);
      fside(1'b0, 7'($random(seed)));
      fside(1'b1, 7'h00);
      rd4();
      $display("forward channel done");
      rmt(REG_CTRL2_OFS, 8'h44, 1'b0);
      fside(1'b1, 7'h00);
      rmt(REG_SER_ADDR_OFS, 8'($random(seed)), 1'b1);
      rd4();
      $display("clear and remote lock done");
      wr(8'h1B, 8'h81, 8'($random(seed)), 3);
      fside(1'b0, 7'h11);
      fside(1'b1, 7'h00);
      r0 = n_rec;
      host.hold(1'b1);
      cyc(500);
      chk("watchdog off", 8'h00, 8'(n_rec - r0));
      host.hold(1'b0);
      rd4();
      $display("local writes done");
      wr(8'h1A, 8'h00, 8'h00, 1);
      ftry({alias0, 1'b0}, 1, 8'(m8));
      ftry(8'h81, 1, 8'h81);
      rmt(REG_SER_ADDR_OFS, 8'h01, 1'b0);
      ftry(8'h80, 0, 8'h00);
      ftry(8'h62, 0, 8'h00);
      pass_all_i = 1'b1;
      ftry(8'h62, 1, 8'h62);
      cyc(150);
      chk("bus free early", 8'h00, {7'h00, bus_free});
      for (i = 0; i < 100 && bus_free !== 1'b1; i++)
         cyc(1);
      chk("bus free", 8'h01, {7'h00, bus_free});
      if (bus_free !== 1'b1)
         give_verdict();
      $display("forwarding done");
      r0 = n_rec;
      host.hold(1'b1);
      cyc(150);
      chk("early pulses", 8'h00, 8'(n_rec - r0));
      for (i = 0; i < 200 && n_rec == r0; i++)
         cyc(1);
      chk("fast expiry", 8'h01, 8'(n_rec - r0));
      if (n_rec == r0)
         give_verdict();
      cyc(17900);
      chk("recovery pulses", 8'h09, 8'(n_rec - r0));
      host.hold(1'b0);
      $display("bus recovery done");
      give_verdict();
   end
endmodule : ccic_core_test
